// *** rtl/twi_host.sv ***
// twi_host: two-wire master driven by software over an axi4-lite slave port
// assumes: one eeprom on the link; scl made here by a divider of aclk
module twi_host #(
	parameter int QUARTER_CYCLES = eeprom_pkg::QUARTER_DEF,
	parameter int ADDR_W         = 8
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// two-wire link
	twi_if.host                    link
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_e;

	host_state_e        hstate_reg;
	eeprom_pkg::op_e    op_reg;
	logic [8:0]         addr_reg;
	logic [7:0]         wbyte_reg;
	logic [7:0]         len_reg;
	logic               nack_reg;
	logic [ADDR_W-1:0]  awaddr_reg;
	logic [31:0]        wdata_reg;
	logic               aw_got_reg;
	logic               w_got_reg;
	logic               bvalid_reg;
	logic [1:0]         bresp_reg;
	logic               rvalid_reg;
	logic [31:0]        rdata_reg;
	logic [1:0]         rresp_reg;
	logic [1:0]         sda_sync_reg;
	logic [7:0]         div_reg;
	logic [1:0]         ph_reg;
	logic [3:0]         bit_cnt_reg;
	logic [7:0]         sh_reg;
	logic               rx_mode_reg;
	logic               rd_ctrl_reg;
	logic [1:0]         stage_reg;
	logic [7:0]         remain_reg;
	logic               scl_oe_reg;
	logic               sda_oe_reg;
	logic               tick;
	logic               stall;
	logic               adv;
	logic               wr_do;
	logic               go;
	logic               rd_take;
	logic               buf_in_valid;
	logic               buf_in_ready;
	logic               buf_out_valid;
	logic               buf_out_ready;
	logic [7:0]         buf_out_data;
	logic               ctrl_rd;

	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = scl_oe_reg;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = sda_oe_reg;

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready  = !w_got_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign wr_do         = aw_got_reg && w_got_reg;
	assign go            = wr_do && awaddr_reg == ADDR_W'(eeprom_pkg::REG_CMD)
		&& hstate_reg == H_IDLE && eeprom_pkg::op_e'(wdata_reg[1:0]) != eeprom_pkg::OP_NONE;
	assign rd_take       = s_axi_arvalid && !rvalid_reg;
	assign buf_out_ready = rd_take && s_axi_araddr == ADDR_W'(eeprom_pkg::REG_RXDATA);

	// receiver back-pressure: hold scl low in the ack slot until the buffer has room
	assign tick         = div_reg == 8'(QUARTER_CYCLES - 1);
	assign buf_in_valid = hstate_reg == H_BIT && rx_mode_reg && bit_cnt_reg == eeprom_pkg::BIT_ACK
		&& ph_reg == 2'h0 && tick;
	assign stall        = buf_in_valid && !buf_in_ready;
	assign adv          = tick && !stall;
	assign ctrl_rd      = op_reg == eeprom_pkg::OP_CUR_READ || stage_reg != 2'h0;

	word_buf #(.WIDTH(8), .DEPTH(2)) rx_buf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (sh_reg),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	// wstrb ignored: every register write is a whole word
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg  <= 32'h0000_0000;
			bvalid_reg <= 1'b0;
			bresp_reg  <= eeprom_pkg::RESP_OKAY;
			addr_reg   <= 9'h000;
			wbyte_reg  <= 8'h00;
			len_reg    <= 8'h00;
			op_reg     <= eeprom_pkg::OP_NONE;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
			end
			if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
			if (wr_do)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= eeprom_pkg::RESP_OKAY;
				if (go)
					op_reg <= eeprom_pkg::op_e'(wdata_reg[1:0]);
				if (awaddr_reg == ADDR_W'(eeprom_pkg::REG_ADDR))
					addr_reg <= wdata_reg[8:0];
				else if (awaddr_reg == ADDR_W'(eeprom_pkg::REG_DATA))
				begin
					wbyte_reg <= wdata_reg[7:0];
					len_reg   <= wdata_reg[eeprom_pkg::DATA_LEN_LSB +: 8];
				end
				else if (awaddr_reg != ADDR_W'(eeprom_pkg::REG_CMD))
					bresp_reg <= eeprom_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= eeprom_pkg::RESP_OKAY;
		end
		else if (rd_take)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= eeprom_pkg::RESP_OKAY;
			if (s_axi_araddr == ADDR_W'(eeprom_pkg::REG_STATUS))
			begin
				rdata_reg[eeprom_pkg::ST_BUSY]    <= hstate_reg != H_IDLE;
				rdata_reg[eeprom_pkg::ST_NACK]    <= nack_reg;
				rdata_reg[eeprom_pkg::ST_RXVALID] <= buf_out_valid;
			end
			else if (s_axi_araddr == ADDR_W'(eeprom_pkg::REG_RXDATA))
				rdata_reg[7:0] <= buf_out_valid ? buf_out_data : 8'h00;
			else if (s_axi_araddr == ADDR_W'(eeprom_pkg::REG_ADDR))
				rdata_reg[8:0] <= addr_reg;
			else if (s_axi_araddr == ADDR_W'(eeprom_pkg::REG_DATA))
				rdata_reg[15:0] <= {len_reg, wbyte_reg};
			else if (s_axi_araddr != ADDR_W'(eeprom_pkg::REG_CMD))
				rresp_reg <= eeprom_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sda_sync_reg <= 2'h3;
		else
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || hstate_reg == H_IDLE)
			div_reg <= 8'h00;
		else if (adv)
			div_reg <= 8'h00;
		else if (!tick)
			div_reg <= div_reg + 8'h01;
	end

	// each phase is one quarter of an scl period; sda moves only while scl is low, except for the start and stop edges
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hstate_reg  <= H_IDLE;
			ph_reg      <= 2'h0;
			bit_cnt_reg <= 4'h0;
			sh_reg      <= 8'h00;
			rx_mode_reg <= 1'b0;
			rd_ctrl_reg <= 1'b0;
			stage_reg   <= 2'h0;
			remain_reg  <= 8'h00;
			scl_oe_reg  <= 1'b0;
			sda_oe_reg  <= 1'b0;
			nack_reg    <= 1'b0;
		end
		else if (go)
		begin
			hstate_reg <= H_START;
			ph_reg     <= 2'h0;
			stage_reg  <= 2'h0;
			nack_reg   <= 1'b0;
		end
		else if (hstate_reg != H_IDLE && adv)
		begin
			ph_reg <= ph_reg + 2'h1;
			unique case (hstate_reg)
				H_START:
				begin
					unique case (ph_reg)
						2'h0: sda_oe_reg <= 1'b0;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b1;
						2'h3:
						begin
							scl_oe_reg  <= 1'b1;
							hstate_reg  <= H_BIT;
							bit_cnt_reg <= 4'h0;
							rx_mode_reg <= 1'b0;
							rd_ctrl_reg <= ctrl_rd;
							sh_reg      <= {eeprom_pkg::DEV_TYPE_CODE, eeprom_pkg::CTRL_DONT_CARE,
								addr_reg[8], ctrl_rd};
						end
					endcase
				end
				H_BIT:
				begin
					unique case (ph_reg)
						2'h0:
						begin
							if (bit_cnt_reg < eeprom_pkg::BIT_ACK)
								sda_oe_reg <= !rx_mode_reg && !sh_reg[7];
							else
								sda_oe_reg <= rx_mode_reg && remain_reg != 8'h00;
						end
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: scl_oe_reg <= 1'b0;
						2'h3:
						begin
							scl_oe_reg <= 1'b1;
							if (bit_cnt_reg < eeprom_pkg::BIT_ACK)
							begin
								sh_reg      <= {sh_reg[6:0], sda_sync_reg[1]};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
							else if (rx_mode_reg)
							begin
								bit_cnt_reg <= 4'h0;
								remain_reg  <= remain_reg - 8'h01;
								if (remain_reg == 8'h00)
									hstate_reg <= H_STOP;
							end
							else if (sda_sync_reg[1])
							begin
								nack_reg   <= 1'b1;
								hstate_reg <= H_STOP;
							end
							else
							begin
								bit_cnt_reg <= 4'h0;
								stage_reg   <= stage_reg + 2'h1;
								if (rd_ctrl_reg)
								begin
									rx_mode_reg <= 1'b1;
									rd_ctrl_reg <= 1'b0;
									remain_reg  <= len_reg;
								end
								else if (stage_reg == 2'h0)
									sh_reg <= addr_reg[7:0];
								else if (stage_reg == 2'h1 && op_reg == eeprom_pkg::OP_WRITE)
									sh_reg <= wbyte_reg;
								else if (stage_reg == 2'h1)
									hstate_reg <= H_START;
								else
									hstate_reg <= H_STOP;
							end
						end
					endcase
				end
				H_STOP:
				begin
					unique case (ph_reg)
						2'h0: sda_oe_reg <= 1'b1;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b0;
						2'h3: hstate_reg <= H_IDLE;
					endcase
				end
				H_IDLE: ph_reg <= 2'h0;
			endcase
		end
	end
endmodule : twi_host

// *** rtl/eeprom_pkg.sv ***
// eeprom_pkg: constants shared by both ends of the two-wire eeprom link
// assumes: both ends clocked by aclk at 125 MHz, synchronous active-low reset
package eeprom_pkg;
	localparam int         WORD_ADDR_W   = 9;
	localparam int         MEM_DEPTH     = 512;
	localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
	localparam int         CTRL_DIR_BIT  = 0;
	localparam int         CTRL_BLK_BIT  = 1;
	localparam int         CTRL_CODE_LSB = 4;
	localparam logic [1:0] CTRL_DONT_CARE = 2'h0;
	localparam logic [3:0] BIT_ACK       = 4'h8;
	localparam logic [3:0] BIT_DONE      = 4'h9;
	localparam logic [3:0] BYTE_MSB      = 4'h7;
	localparam logic [7:0] MEM_INIT      = 8'hFF;
	localparam int         QUARTER_DEF   = 4;
	localparam int         WRITE_CYC_DEF = 1000;
	// controller register byte offsets
	localparam logic [7:0] REG_CMD       = 8'h00;
	localparam logic [7:0] REG_ADDR      = 8'h04;
	localparam logic [7:0] REG_DATA      = 8'h08;
	localparam logic [7:0] REG_STATUS    = 8'h0C;
	localparam logic [7:0] REG_RXDATA    = 8'h10;
	localparam int         ST_BUSY       = 0;
	localparam int         ST_NACK       = 1;
	localparam int         ST_RXVALID    = 2;
	localparam int         DATA_LEN_LSB  = 8;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_RAND_READ, OP_CUR_READ} op_e;
endpackage : eeprom_pkg

// *** rtl/twi_if.sv ***
// twi_if: the two open-drain wires between controller and eeprom
// assumes: external pull-ups, modelled here as a wired-and of the enables
interface twi_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface : twi_if

// *** rtl/word_buf.sv ***
// word_buf: small fifo with valid/ready on both sides
// assumes: single clock, producer holds valid and data until ready
module word_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = count_reg != CW'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data  = mem_reg[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge aclk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
			if (push && !pop)
				count_reg <= count_reg + CW'(1);
			else if (pop && !push)
				count_reg <= count_reg - CW'(1);
		end
	end
endmodule : word_buf

// *** rtl/eeprom_dev.sv ***
// eeprom_dev: 512-byte two-wire eeprom slave, read path plus minimal byte write
// assumes: scl/sda arrive asynchronously and are oversampled by aclk
// Function
// - read starts like write, direction bit one
// - pointer holds last accessed location plus one
// - acknowledge read control, send byte at pointer
// - master nack plus stop ends read; release
// - master loads word address via write first
// - repeated start abandons write, keeps pointer
// - master resends control byte with read direction
// - master ack requests next sequential byte
// - pointer increments after every byte
// - low supply blocks erase and write
// - sda change while scl high is start/stop
// - sda only pulled low or released
// - protect low allows full-range read and write
// - protect high refuses writes, reads unchanged
// - chip address pins ignored entirely
// - acknowledge only device type code controls
// - block select is word address msb
// - no acknowledge during internal write cycle
module eeprom_dev #(
	parameter int WRITE_CYC_CYCLES = eeprom_pkg::WRITE_CYC_DEF
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// two-wire link
	twi_if.dev        link,
	// device pins
	input  wire logic wp,
	input  wire logic supply_low,
	input  wire logic unused_chip_addr_pin_0,
	input  wire logic unused_chip_addr_pin_1,
	input  wire logic unused_chip_addr_pin_2
);
	localparam int AW = eeprom_pkg::WORD_ADDR_W;
	localparam int BW = $clog2(WRITE_CYC_CYCLES + 1);

	typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_WADDR, ST_WDATA, ST_RDATA} dev_state_e;

	logic [7:0]    mem_reg [eeprom_pkg::MEM_DEPTH];
	logic [1:0]    scl_sync_reg;
	logic [1:0]    sda_sync_reg;
	logic [1:0]    wp_sync_reg;
	logic [1:0]    low_sync_reg;
	logic          scl_prev_reg;
	logic          sda_prev_reg;
	dev_state_e    state_reg;
	logic [3:0]    bit_cnt_reg;
	logic [7:0]    rx_reg;
	logic [7:0]    tx_reg;
	logic [AW-1:0] ptr_reg;
	logic          read_dir_reg;
	logic          acked_reg;
	logic          sda_oe_reg;
	logic          pend_valid_reg;
	logic [AW-1:0] pend_addr_reg;
	logic [7:0]    pend_data_reg;
	logic [BW-1:0] busy_cnt_reg;
	logic          scl;
	logic          sda;
	logic          scl_rise;
	logic          scl_fall;
	logic          start_cond;
	logic          stop_cond;
	logic          busy;
	logic          commit;
	logic          code_ok;
	logic [7:0]    mem_rd;

	// chip address pins deliberately left unread
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_oe_reg;

	// synchronisers; the second stage is the only reader of the first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			wp_sync_reg  <= 2'h0;
			low_sync_reg <= 2'h0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], link.scl};
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			wp_sync_reg  <= {wp_sync_reg[0], wp};
			low_sync_reg <= {low_sync_reg[0], supply_low};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl        = scl_sync_reg[1];
	assign sda        = sda_sync_reg[1];
	assign scl_rise   = scl && !scl_prev_reg;
	assign scl_fall   = !scl && scl_prev_reg;
	assign start_cond = scl && scl_prev_reg && sda_prev_reg && !sda;
	assign stop_cond  = scl && scl_prev_reg && !sda_prev_reg && sda;
	assign busy       = busy_cnt_reg != '0;
	assign code_ok    = rx_reg[7:eeprom_pkg::CTRL_CODE_LSB] == eeprom_pkg::DEV_TYPE_CODE;
	assign mem_rd     = mem_reg[ptr_reg];
	// protect pin and low supply gate only the array write, never a read
	assign commit     = stop_cond && pend_valid_reg && !wp_sync_reg[1]
		&& !low_sync_reg[1] && !busy;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < eeprom_pkg::MEM_DEPTH; i++)
				mem_reg[i] <= eeprom_pkg::MEM_INIT;
		end
		else if (commit)
			mem_reg[pend_addr_reg] <= pend_data_reg;
	end

	// self-timed write cycle; the link is deaf to control bytes meanwhile
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			busy_cnt_reg <= '0;
		else if (commit)
			busy_cnt_reg <= BW'(WRITE_CYC_CYCLES);
		else if (busy)
			busy_cnt_reg <= busy_cnt_reg - BW'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg      <= ST_IDLE;
			bit_cnt_reg    <= 4'h0;
			rx_reg         <= 8'h00;
			tx_reg         <= 8'h00;
			ptr_reg        <= '0;
			read_dir_reg   <= 1'b0;
			acked_reg      <= 1'b0;
			sda_oe_reg     <= 1'b0;
			pend_valid_reg <= 1'b0;
			pend_addr_reg  <= '0;
			pend_data_reg  <= 8'h00;
		end
		else if (start_cond)
		begin
			state_reg      <= ST_CTRL;
			bit_cnt_reg    <= 4'h0;
			sda_oe_reg     <= 1'b0;
			pend_valid_reg <= 1'b0;
		end
		else if (stop_cond)
		begin
			state_reg      <= ST_IDLE;
			sda_oe_reg     <= 1'b0;
			pend_valid_reg <= 1'b0;
		end
		else if (scl_rise && state_reg != ST_IDLE)
		begin
			if (bit_cnt_reg < eeprom_pkg::BIT_ACK)
			begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (state_reg != ST_RDATA)
					rx_reg <= {rx_reg[6:0], sda};
			end
			else if (bit_cnt_reg == eeprom_pkg::BIT_ACK)
			begin
				bit_cnt_reg <= eeprom_pkg::BIT_DONE;
				if (state_reg == ST_RDATA)
					acked_reg <= !sda;
			end
		end
		else if (scl_fall && state_reg != ST_IDLE)
		begin
			if (bit_cnt_reg == eeprom_pkg::BIT_ACK)
			begin
				unique case (state_reg)
					ST_CTRL:
					begin
						if (code_ok && !busy)
						begin
							sda_oe_reg   <= 1'b1;
							ptr_reg[AW-1] <= rx_reg[eeprom_pkg::CTRL_BLK_BIT];
							read_dir_reg <= rx_reg[eeprom_pkg::CTRL_DIR_BIT];
						end
						else
							state_reg <= ST_IDLE;
					end
					ST_WADDR:
					begin
						sda_oe_reg   <= 1'b1;
						ptr_reg[7:0] <= rx_reg;
					end
					ST_WDATA:
					begin
						sda_oe_reg     <= 1'b1;
						pend_valid_reg <= 1'b1;
						pend_addr_reg  <= ptr_reg;
						pend_data_reg  <= rx_reg;
						ptr_reg        <= ptr_reg + AW'(1);
					end
					ST_RDATA:
						sda_oe_reg <= 1'b0;
					ST_IDLE:
						sda_oe_reg <= 1'b0;
				endcase
			end
			else if (bit_cnt_reg == eeprom_pkg::BIT_DONE)
			begin
				bit_cnt_reg <= 4'h0;
				sda_oe_reg  <= 1'b0;
				if ((state_reg == ST_CTRL && read_dir_reg) || (state_reg == ST_RDATA && acked_reg))
				begin
					// first bit goes out on this same falling edge
					state_reg  <= ST_RDATA;
					tx_reg     <= mem_rd;
					sda_oe_reg <= !mem_rd[7];
					ptr_reg    <= ptr_reg + AW'(1);
				end
				else if (state_reg == ST_CTRL)
					state_reg <= ST_WADDR;
				else if (state_reg == ST_RDATA)
					state_reg <= ST_IDLE;
				else
					state_reg <= ST_WDATA;
			end
			else if (state_reg == ST_RDATA)
				sda_oe_reg <= !tx_reg[3'(eeprom_pkg::BYTE_MSB - bit_cnt_reg)];
		end
	end
endmodule : eeprom_dev

// *** dv/eeprom_asserts.sv ***
// eeprom_asserts: timing checks on the shared two-wire lines
// assumes: instantiated beside the link interface, one aclk domain
module eeprom_asserts (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// resolved lines
	input logic scl,
	input logic sda,
	// drivers
	input logic host_scl_o,
	input logic host_scl_oe,
	input logic host_sda_o,
	input logic host_sda_oe,
	input logic dev_sda_o,
	input logic dev_sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence start_cond;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_cond;
		scl && $past(scl) && $rose(sda);
	endsequence

	a_dev_pull_only: assert property (dev_sda_o == 1'b0)
		else $error("device drives sda high");
	a_host_pull_only: assert property (host_sda_o == 1'b0 && host_scl_o == 1'b0)
		else $error("host drives a line high");
	a_dev_sda_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("device moved sda while scl high");
	a_ack_in_low: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("device pulled sda with scl high");
	a_stop_released: assert property (stop_cond |=> !dev_sda_oe [*8])
		else $error("device drives sda after stop");
	a_start_released: assert property (start_cond |-> !dev_sda_oe [*8])
		else $error("device drives sda after start");
	a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
		else $error("scl high phase too short");
	a_scl_low_min: assert property ($fell(scl) |-> !scl [*4])
		else $error("scl low phase too short");
	a_host_sda_hold: assert property ($rose(scl) |-> $stable(host_sda_oe) [*3])
		else $error("host moved sda early in scl high");
endmodule : eeprom_asserts

// *** dv/test_serial_eeprom_read_path.sv ***
// test_serial_eeprom_read_path: host and eeprom joined, driven over axi4-lite
// assumes: eeprom_pkg, twi_if, word_buf, twi_host, eeprom_dev and eeprom_asserts compiled first
module test_serial_eeprom_read_path;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
	logic        arvalid, arready, rvalid, wp, supply_low;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [2:0]  upin;
	logic [7:0]  rx[$];
	int          num_errors, compares;

	twi_if link ();
	twi_host #(.QUARTER_CYCLES(4)) i_twi_host (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .link(link));
	// long write cycle so a read can land inside it
	eeprom_dev #(.WRITE_CYC_CYCLES(2000)) i_eeprom_dev (.aclk(aclk), .aresetn(aresetn),
		.link(link), .wp(wp), .supply_low(supply_low), .unused_chip_addr_pin_0(upin[0]),
		.unused_chip_addr_pin_1(upin[1]), .unused_chip_addr_pin_2(upin[2]));
	eeprom_asserts i_eeprom_asserts (.aclk(aclk), .aresetn(aresetn), .scl(link.scl),
		.sda(link.sda), .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
		.host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// handshakes sampled at the falling edge, acted on at the next rising one
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic       ah, wh, bh;
		logic [1:0] br;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			br = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		while (!bh);
		chk({30'h0, br}, {30'h0, eeprom_pkg::RESP_OKAY});
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
		end
		while (!rh);
	endtask : axi_rd

	// polls status and pops bytes as they come; host stalls while buffer is full
	task automatic run_op(input eeprom_pkg::op_e op, input logic [8:0] a,
		input logic [15:0] ctl, output logic nk);
		logic [31:0] st, d;
		logic [1:0]  r;
		rx.delete();
		axi_wr(eeprom_pkg::REG_ADDR, {23'h0, a});
		axi_wr(eeprom_pkg::REG_DATA, {16'h0, ctl});
		axi_wr(eeprom_pkg::REG_CMD, {30'h0, op});
		do
		begin
			axi_rd(eeprom_pkg::REG_STATUS, st, r);
			if (st[eeprom_pkg::ST_RXVALID])
			begin
				axi_rd(eeprom_pkg::REG_RXDATA, d, r);
				rx.push_back(d[7:0]);
			end
		end
		while (st[eeprom_pkg::ST_BUSY] || st[eeprom_pkg::ST_RXVALID]);
		nk = st[eeprom_pkg::ST_NACK];
	endtask : run_op

	task automatic wr(input logic [8:0] a, input logic [7:0] b);
		logic nk;
		upin <= a[2:0] ^ upin;
		run_op(eeprom_pkg::OP_WRITE, a, {8'h0, b}, nk);
		chk({31'h0, nk}, 32'h0);
		repeat (2100) @(posedge aclk);
	endtask : wr

	task automatic rd_chk(input eeprom_pkg::op_e op, input logic [8:0] a, input int n,
		input logic [31:0] exp);
		logic nk;
		run_op(op, a, {n[7:0] - 8'h01, 8'h0}, nk);
		chk({31'h0, nk}, 32'h0);
		chk(rx.size(), n);
		for (int i = 0; i < n; i++)
			chk({24'h0, rx[i]}, {24'h0, exp[8*i+:8]});
	endtask : rd_chk

	task automatic t_busy_refuse();
		logic nk;
		run_op(eeprom_pkg::OP_WRITE, 9'h1FE, 16'h005A, nk);
		run_op(eeprom_pkg::OP_RAND_READ, 9'h1FE, 16'h0000, nk);
		chk({31'h0, nk}, 32'h1);
		repeat (2100) @(posedge aclk);
		rd_chk(eeprom_pkg::OP_RAND_READ, 9'h1FE, 1, 32'h5A);
	endtask : t_busy_refuse

	task automatic t_seq_wrap();
		wr(9'h1FF, 8'hA5);
		wr(9'h000, 8'h3C);
		wr(9'h001, 8'hC3);
		rd_chk(eeprom_pkg::OP_RAND_READ, 9'h1FE, 4, 32'hC33CA55A);
		rd_chk(eeprom_pkg::OP_CUR_READ, 9'h000, 1, 32'hFF);
		rd_chk(eeprom_pkg::OP_RAND_READ, 9'h1FF, 1, 32'hA5);
		rd_chk(eeprom_pkg::OP_CUR_READ, 9'h000, 1, 32'h3C);
	endtask : t_seq_wrap

	task automatic t_protect();
		logic [31:0] d;
		logic [1:0]  r;
		wp <= 1'b1;
		wr(9'h000, 8'h11);
		wp <= 1'b0;
		supply_low <= 1'b1;
		wr(9'h001, 8'h22);
		supply_low <= 1'b0;
		rd_chk(eeprom_pkg::OP_RAND_READ, 9'h000, 2, 32'hC33C);
		axi_rd(8'h20, d, r);
		chk({30'h0, r}, {30'h0, eeprom_pkg::RESP_SLVERR});
	endtask : t_protect

	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	initial
	begin
		#400000;
		num_errors++;
		$display("mismatch at %0t: run timed out", $time);
		stop_test();
	end

	initial
	begin
		{aresetn, awvalid, wvalid, arvalid, wp, supply_low, upin} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_busy_refuse();
		t_seq_wrap();
		t_protect();
		stop_test();
	end
endmodule : test_serial_eeprom_read_path
